// >>> design/pcx_crossbar.sv
// Priority pin crossbar with its configuration registers.
// Contract
// - UART ranks highest, assigned first.
// - Each enabled resource after UART takes lowest free pin.
// - Pins given earlier are passed over.
// - Skipped pins count as occupied.
// - UART transmit on P0.4, receive on P0.5.
// - SMBus claims data and clock together.
// - Leftover pins are ordinary port I/O.
// - SPI takes four pins only in 4-wire mode.
// - SMBus signal order follows its swap bit.
// - Crossbar off makes every pin an input.
// - Crossbar off disables all output drivers.
// - Input-mode bit one digital, zero analog.
// - Analog pin: no pull-up, driver, receiver.
// - Reset leaves every pin digital.
// - SMBus pins always drive open-drain.
// - Weak pull-up on open-drain pins when enabled.
// - Pull-up off while pin drives low.
// - Low route register holds one enable each.
// - Bit seven enables strong pull-ups P2.2, P2.3.
// - Global pull-up-off bit disables all weak pull-ups.
// - Analog pin reads back as zero.
// - Counter-array field routes zero to three outputs.
`timescale 1ns/1ps
`default_nettype none
module pcx_crossbar (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    input wire logic sfr_re,
    output logic [7:0] sfr_rdata,
    input wire logic [1:0] spi_select_mode,
    input wire logic [1:0] smbus_pin_swap,
    input wire logic [pcx_pkg::PCX_NFN-1:0] fn_out,
    input wire logic [pcx_pkg::PCX_NFN-1:0] fn_oe,
    output logic [pcx_pkg::PCX_NFN-1:0] fn_in,
    input wire logic [pcx_pkg::PCX_NPIN-1:0] pad_in,
    output logic [pcx_pkg::PCX_NPIN-1:0] pad_out,
    output logic [pcx_pkg::PCX_NPIN-1:0] pad_oe_n,
    output logic [pcx_pkg::PCX_NPIN-1:0] pad_weak_pu,
    output logic strong_pullup_on
);
    import pcx_pkg::*;

    typedef struct packed {
        logic [7:0] route_lo;
        logic [7:0] route_hi;
        logic [PCX_NPIN-1:0] latch;
        logic [PCX_NPIN-1:0] skip;
        logic [PCX_NPIN-1:0] mdin;
        logic [PCX_NPIN-1:0] mdout;
        pcx_map_t map;
        logic [PCX_NPIN-1:0] out;
        logic [PCX_NPIN-1:0] oe_n;
        logic [PCX_NPIN-1:0] weak_pu;
        logic [PCX_NPIN-1:0] rx;
        logic [PCX_NFN-1:0] fn_in;
        logic [7:0] rdata;
    } pcx_state_t;

    pcx_state_t st_q;
    pcx_state_t st_d;

    pcx_pad_if pads ();

    pcx_pad_bank u_pads (
        .pads(pads)
    );

    logic crossbar_on;
    logic global_pullup_off;
    logic [PCX_NFN-1:0] slot_en;
    logic [1:0] cex_field;
    pcx_map_t map_d;

    assign crossbar_on = st_q.route_hi[PCX_B_CROSSBAR_ON];
    assign global_pullup_off = st_q.route_hi[PCX_B_PULLUP_OFF];
    assign cex_field = st_q.route_hi[PCX_B_CEX_LO +: 2];

    // Places one port byte into a pin vector; port 2 has four pins.
    function automatic logic [PCX_NPIN-1:0] put_port(
        input logic [PCX_NPIN-1:0] v,
        input logic [1:0] port,
        input logic [7:0] d
    );
        logic [PCX_NPIN+3:0] t;
        t = {PCX_PAD_HI, v};
        t[port*PCX_PORT_BITS +: PCX_PORT_BITS] = d;
        return t[PCX_NPIN-1:0];
    endfunction

    // Reads one port byte; missing bits of port 2 read as zero.
    function automatic logic [7:0] get_port(
        input logic [PCX_NPIN-1:0] v,
        input logic [1:0] port
    );
        logic [PCX_NPIN+3:0] t;
        t = {PCX_PAD_HI, v};
        return t[port*PCX_PORT_BITS +: PCX_PORT_BITS];
    endfunction

    // Resource enables in priority order.
    always_comb begin
        slot_en = '0;
        slot_en[PCX_F_UART_TX] = st_q.route_lo[PCX_B_UART];
        slot_en[PCX_F_UART_RX] = st_q.route_lo[PCX_B_UART];
        slot_en[PCX_F_SPI_SCK] = st_q.route_lo[PCX_B_SPI];
        slot_en[PCX_F_SPI_MISO] = st_q.route_lo[PCX_B_SPI];
        slot_en[PCX_F_SPI_MOSI] = st_q.route_lo[PCX_B_SPI];
        slot_en[PCX_F_SPI_NSS] = st_q.route_lo[PCX_B_SPI] &&
            spi_select_mode != PCX_SPI_3WIRE;
        slot_en[PCX_F_SMB0_SDA] = st_q.route_lo[PCX_B_SMB0];
        slot_en[PCX_F_SMB0_SCL] = st_q.route_lo[PCX_B_SMB0];
        slot_en[PCX_F_SMB1_SDA] = st_q.route_lo[PCX_B_SMB1];
        slot_en[PCX_F_SMB1_SCL] = st_q.route_lo[PCX_B_SMB1];
        slot_en[PCX_F_CMP] = st_q.route_lo[PCX_B_CMP];
        slot_en[PCX_F_CMPA] = st_q.route_lo[PCX_B_CMPA];
        slot_en[PCX_F_SYSCLK] = st_q.route_lo[PCX_B_SYSCLK];
        slot_en[PCX_F_CAPTURE_COMPARE_OUT] = cex_field != '0;
        slot_en[PCX_F_CEX1] = cex_field == PCX_CEX_TWO ||
            cex_field == PCX_CEX_THREE;
        slot_en[PCX_F_CEX2] = cex_field == PCX_CEX_THREE;
        slot_en[PCX_F_ECI] = st_q.route_hi[PCX_B_ECI];
        slot_en[PCX_F_T0] = st_q.route_hi[PCX_B_T0];
        slot_en[PCX_F_T1] = st_q.route_hi[PCX_B_T1];
    end

    // Priority decoder: walks the slots after UART and hands each the lowest free pin.
    always_comb begin
        logic [PCX_NPIN-1:0] taken;
        logic found;
        int fid;
        taken = st_q.skip;
        found = 1'b0;
        fid = 0;
        map_d = '0;
        if (slot_en[PCX_F_UART_TX]) begin
            // The serial port sits on fixed pins and is placed first.
            map_d[PCX_PIN_UART_TX] = PCX_MAPW'(PCX_F_UART_TX + 1);
            map_d[PCX_PIN_UART_RX] = PCX_MAPW'(PCX_F_UART_RX + 1);
            taken[PCX_PIN_UART_TX] = 1'b1;
            taken[PCX_PIN_UART_RX] = 1'b1;
        end
        for (int s = PCX_F_SPI_SCK; s < PCX_NFN; s++) begin
            fid = s;
            if (s == PCX_F_SMB0_SDA && smbus_pin_swap[0]) begin
                fid = PCX_F_SMB0_SCL;
            end else if (s == PCX_F_SMB0_SCL && smbus_pin_swap[0]) begin
                fid = PCX_F_SMB0_SDA;
            end else if (s == PCX_F_SMB1_SDA && smbus_pin_swap[1]) begin
                fid = PCX_F_SMB1_SCL;
            end else if (s == PCX_F_SMB1_SCL && smbus_pin_swap[1]) begin
                fid = PCX_F_SMB1_SDA;
            end
            found = 1'b0;
            for (int p = 0; p < PCX_NPIN; p++) begin
                if (slot_en[s] && !found && !taken[p]) begin
                    map_d[p] = PCX_MAPW'(fid + 1);
                    taken[p] = 1'b1;
                    found = 1'b1;
                end
            end
        end
    end

    // Drive requests towards the pad bank.
    always_comb begin
        int f;
        f = 0;
        pads.analog = ~st_q.mdin;
        pads.push_pull = st_q.mdout;
        pads.pullup_off = global_pullup_off;
        pads.pad_in = pad_in;
        pads.drive_en = '0;
        pads.drive_val = '0;
        pads.od_force = '0;
        for (int p = 0; p < PCX_NPIN; p++) begin
            f = int'(st_q.map[p]) - 1;
            if (!crossbar_on) begin
                pads.drive_en[p] = 1'b0;
            end else if (st_q.map[p] == PCX_MAP_GPIO) begin
                pads.drive_en[p] = 1'b1;
                pads.drive_val[p] = st_q.latch[p];
            end else begin
                pads.drive_en[p] = fn_oe[f];
                pads.drive_val[p] = fn_out[f];
                pads.od_force[p] = f >= PCX_F_SMB0_SDA &&
                    f <= PCX_F_SMB1_SCL;
            end
        end
    end

    // Next state: register port, routed inputs and registered pad outputs.
    always_comb begin
        int f;
        f = 0;
        st_d = st_q;
        st_d.map = map_d;
        st_d.out = pads.out;
        st_d.oe_n = pads.oe_n;
        st_d.weak_pu = pads.weak_pu;
        st_d.rx = pads.rx;
        st_d.fn_in = '0;
        for (int p = 0; p < PCX_NPIN; p++) begin
            f = int'(st_q.map[p]) - 1;
            if (crossbar_on && st_q.map[p] != PCX_MAP_GPIO) begin
                st_d.fn_in[f] = pads.rx[p];
            end
        end
        if (sfr_we) begin
            unique case (sfr_addr)
                PCX_A_ROUTE_LO: st_d.route_lo = sfr_wdata;
                PCX_A_ROUTE_HI: st_d.route_hi = sfr_wdata & PCX_ROUTE_HI_MASK;
                PCX_A_LATCH0: st_d.latch = put_port(st_q.latch, PCX_PORT0,
                    sfr_wdata);
                PCX_A_LATCH1: st_d.latch = put_port(st_q.latch, PCX_PORT1,
                    sfr_wdata);
                PCX_A_LATCH2: st_d.latch = put_port(st_q.latch, PCX_PORT2,
                    sfr_wdata);
                PCX_A_SKIP0: st_d.skip = put_port(st_q.skip, PCX_PORT0,
                    sfr_wdata);
                PCX_A_SKIP1: st_d.skip = put_port(st_q.skip, PCX_PORT1,
                    sfr_wdata);
                PCX_A_SKIP2: st_d.skip = put_port(st_q.skip, PCX_PORT2,
                    sfr_wdata);
                PCX_A_MDIN0: st_d.mdin = put_port(st_q.mdin, PCX_PORT0,
                    sfr_wdata);
                PCX_A_MDIN1: st_d.mdin = put_port(st_q.mdin, PCX_PORT1,
                    sfr_wdata);
                PCX_A_MDIN2: st_d.mdin = put_port(st_q.mdin, PCX_PORT2,
                    sfr_wdata);
                PCX_A_MDOUT0: st_d.mdout = put_port(st_q.mdout, PCX_PORT0,
                    sfr_wdata);
                PCX_A_MDOUT1: st_d.mdout = put_port(st_q.mdout, PCX_PORT1,
                    sfr_wdata);
                PCX_A_MDOUT2: st_d.mdout = put_port(st_q.mdout, PCX_PORT2,
                    sfr_wdata);
                default: st_d.rdata = st_q.rdata;
            endcase
        end
        // Port addresses read the pads; analog pins already read zero.
        if (sfr_re) begin
            unique case (sfr_addr)
                PCX_A_ROUTE_LO: st_d.rdata = st_q.route_lo;
                PCX_A_ROUTE_HI: st_d.rdata = st_q.route_hi;
                PCX_A_LATCH0: st_d.rdata = get_port(st_q.rx, PCX_PORT0);
                PCX_A_LATCH1: st_d.rdata = get_port(st_q.rx, PCX_PORT1);
                PCX_A_LATCH2: st_d.rdata = get_port(st_q.rx, PCX_PORT2);
                PCX_A_SKIP0: st_d.rdata = get_port(st_q.skip, PCX_PORT0);
                PCX_A_SKIP1: st_d.rdata = get_port(st_q.skip, PCX_PORT1);
                PCX_A_SKIP2: st_d.rdata = get_port(st_q.skip, PCX_PORT2);
                PCX_A_MDIN0: st_d.rdata = get_port(st_q.mdin, PCX_PORT0);
                PCX_A_MDIN1: st_d.rdata = get_port(st_q.mdin, PCX_PORT1);
                PCX_A_MDIN2: st_d.rdata = get_port(st_q.mdin, PCX_PORT2);
                PCX_A_MDOUT0: st_d.rdata = get_port(st_q.mdout, PCX_PORT0);
                PCX_A_MDOUT1: st_d.rdata = get_port(st_q.mdout, PCX_PORT1);
                PCX_A_MDOUT2: st_d.rdata = get_port(st_q.mdout, PCX_PORT2);
                default: st_d.rdata = PCX_REG8_RST;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q <= '0;
            st_q.mdin <= PCX_MDIN_RST;
            st_q.oe_n <= ~PCX_PINS_CLR;
            st_q.weak_pu <= ~PCX_PINS_CLR;
        end else begin
            st_q <= st_d;
        end
    end

    assign sfr_rdata = st_q.rdata;
    assign fn_in = st_q.fn_in;
    assign pad_out = st_q.out;
    assign pad_oe_n = st_q.oe_n;
    assign pad_weak_pu = st_q.weak_pu;
    // Strong pull-ups of P2.2 and P2.3 follow one control bit.
    assign strong_pullup_on = st_q.route_lo[PCX_B_STRONG_PU];
endmodule // pcx_crossbar
`default_nettype wire

// >>> design/pcx_pad_bank.sv
// Output driver, weak pull-up and receiver logic of every port pin.
`timescale 1ns/1ps
`default_nettype none
module pcx_pad_bank (
    pcx_pad_if.bank pads
);
    import pcx_pkg::*;

    logic [PCX_NPIN-1:0] open_drain;
    logic [PCX_NPIN-1:0] drive;

    always_comb begin
        for (int p = 0; p < PCX_NPIN; p++) begin
            // Software picks the mode per pin; SMBus pins force open-drain.
            open_drain[p] = !pads.push_pull[p] || pads.od_force[p];
            // Analog pins never drive; open-drain only drives a low.
            drive[p] = pads.drive_en[p] && pads.analog[p] == 1'b0 &&
                (!open_drain[p] || !pads.drive_val[p]);
            pads.oe_n[p] = !drive[p];
            pads.out[p] = pads.drive_val[p] && !open_drain[p];
            // Pull-up is off for analog pins, globally, or while driving.
            pads.weak_pu[p] = !pads.analog[p] && !pads.pullup_off &&
                !drive[p];
            pads.rx[p] = pads.analog[p] ? 1'b0 : pads.pad_in[p];
        end
    end
endmodule // pcx_pad_bank
`default_nettype wire

// >>> include/pcx_pad_if.sv
// Per-pin drive request and pad result between crossbar and pad bank.
`timescale 1ns/1ps
`default_nettype none
interface pcx_pad_if;
    logic [19:0] analog;
    logic [19:0] push_pull;
    logic [19:0] drive_en;
    logic [19:0] drive_val;
    logic [19:0] od_force;
    logic [19:0] pad_in;
    logic pullup_off;
    logic [19:0] out;
    logic [19:0] oe_n;
    logic [19:0] weak_pu;
    logic [19:0] rx;
    modport ctrl (
        output analog, push_pull, drive_en, drive_val, od_force, pad_in,
        output pullup_off,
        input out, oe_n, weak_pu, rx
    );
    modport bank (
        input analog, push_pull, drive_en, drive_val, od_force, pad_in,
        input pullup_off,
        output out, oe_n, weak_pu, rx
    );
endinterface
`default_nettype wire

// >>> include/pcx_pkg.sv
// Constants and types shared by the priority pin crossbar design.
package pcx_pkg;
    localparam int PCX_NPIN = 20;
    localparam int PCX_NFN = 19;
    localparam int PCX_MAPW = 5;

    // Register addresses on the special function register port.
    localparam logic [7:0] PCX_A_ROUTE_LO = 8'hE1;
    localparam logic [7:0] PCX_A_ROUTE_HI = 8'hE2;
    localparam logic [7:0] PCX_A_LATCH0 = 8'h80;
    localparam logic [7:0] PCX_A_LATCH1 = 8'h90;
    localparam logic [7:0] PCX_A_LATCH2 = 8'hA0;
    localparam logic [7:0] PCX_A_SKIP0 = 8'hD4;
    localparam logic [7:0] PCX_A_SKIP1 = 8'hD5;
    localparam logic [7:0] PCX_A_SKIP2 = 8'hD6;
    localparam logic [7:0] PCX_A_MDIN0 = 8'hF1;
    localparam logic [7:0] PCX_A_MDIN1 = 8'hF2;
    localparam logic [7:0] PCX_A_MDIN2 = 8'hF3;
    localparam logic [7:0] PCX_A_MDOUT0 = 8'hA4;
    localparam logic [7:0] PCX_A_MDOUT1 = 8'hA5;
    localparam logic [7:0] PCX_A_MDOUT2 = 8'hA6;

    // Port index within a group of three per-port registers.
    localparam logic [1:0] PCX_PORT0 = 2'h0;
    localparam logic [1:0] PCX_PORT1 = 2'h1;
    localparam logic [1:0] PCX_PORT2 = 2'h2;
    localparam int PCX_PORT_BITS = 8;

    // Fields of crossbar_route_enables_low.
    localparam int PCX_B_UART = 0;
    localparam int PCX_B_SPI = 1;
    localparam int PCX_B_SMB0 = 2;
    localparam int PCX_B_SYSCLK = 3;
    localparam int PCX_B_CMP = 4;
    localparam int PCX_B_CMPA = 5;
    localparam int PCX_B_SMB1 = 6;
    localparam int PCX_B_STRONG_PU = 7;
    // Fields of crossbar_route_enables_high.
    localparam int PCX_B_CEX_LO = 0;
    localparam int PCX_B_ECI = 3;
    localparam int PCX_B_T0 = 4;
    localparam int PCX_B_T1 = 5;
    localparam int PCX_B_CROSSBAR_ON = 6;
    localparam int PCX_B_PULLUP_OFF = 7;
    localparam logic [7:0] PCX_ROUTE_HI_MASK = 8'hFB;

    // Function slots, in descending priority.
    localparam int PCX_F_UART_TX = 0;
    localparam int PCX_F_UART_RX = 1;
    localparam int PCX_F_SPI_SCK = 2;
    localparam int PCX_F_SPI_MISO = 3;
    localparam int PCX_F_SPI_MOSI = 4;
    localparam int PCX_F_SPI_NSS = 5;
    localparam int PCX_F_SMB0_SDA = 6;
    localparam int PCX_F_SMB0_SCL = 7;
    localparam int PCX_F_SMB1_SDA = 8;
    localparam int PCX_F_SMB1_SCL = 9;
    localparam int PCX_F_CMP = 10;
    localparam int PCX_F_CMPA = 11;
    localparam int PCX_F_SYSCLK = 12;
    localparam int PCX_F_CAPTURE_COMPARE_OUT = 13;
    localparam int PCX_F_CEX1 = 14;
    localparam int PCX_F_CEX2 = 15;
    localparam int PCX_F_ECI = 16;
    localparam int PCX_F_T0 = 17;
    localparam int PCX_F_T1 = 18;

    // Fixed serial port pins.
    localparam int PCX_PIN_UART_TX = 4;
    localparam int PCX_PIN_UART_RX = 5;

    localparam logic [1:0] PCX_SPI_3WIRE = 2'h0;
    localparam logic [1:0] PCX_CEX_ONE = 2'h1;
    localparam logic [1:0] PCX_CEX_TWO = 2'h2;
    localparam logic [1:0] PCX_CEX_THREE = 2'h3;

    localparam logic [4:0] PCX_MAP_GPIO = 5'h00;
    localparam logic [7:0] PCX_REG8_RST = 8'h00;
    localparam logic [19:0] PCX_PINS_CLR = 20'h0_0000;
    localparam logic [19:0] PCX_MDIN_RST = 20'hF_FFFF;
    localparam logic [3:0] PCX_PAD_HI = 4'h0;

    typedef logic [PCX_NPIN-1:0][PCX_MAPW-1:0] pcx_map_t;
endpackage

// >>> sim/pcx_crossbar_props.sv
// Port assertions for the priority pin crossbar.
`timescale 1ns/1ps
`default_nettype none
module pcx_crossbar_props (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_we,
    input wire logic sfr_re,
    input wire logic [7:0] sfr_rdata,
    input wire logic [pcx_pkg::PCX_NFN-1:0] fn_in,
    input wire logic [pcx_pkg::PCX_NPIN-1:0] pad_out,
    input wire logic [pcx_pkg::PCX_NPIN-1:0] pad_oe_n,
    input wire logic [pcx_pkg::PCX_NPIN-1:0] pad_weak_pu,
    input wire logic strong_pullup_on
);
    import pcx_pkg::*;
    logic [7:0] lo_q;
    logic [7:0] hi_q;
    logic [1:0] offc_q;
    logic [1:0] pudc_q;
    logic mapped;
    assign mapped = sfr_addr inside {8'h80, 8'h90, 8'hA0, [8'hA4:8'hA6],
        [8'hD4:8'hD6], [8'hE1:8'hE2], [8'hF1:8'hF3]};
    // Shadow route registers and count how long each global bit has held.
    always_ff @(posedge mclk) begin
        if (rst) begin
            lo_q <= 8'h00;
            hi_q <= 8'h00;
            offc_q <= 2'h0;
            pudc_q <= 2'h0;
        end else begin
            if (sfr_we && sfr_addr == PCX_A_ROUTE_LO) lo_q <= sfr_wdata;
            if (sfr_we && sfr_addr == PCX_A_ROUTE_HI) hi_q <= sfr_wdata;
            offc_q <= hi_q[6] ? 2'h0 : offc_q + 2'(offc_q != 2'h3);
            pudc_q <= !hi_q[7] ? 2'h0 : pudc_q + 2'(pudc_q != 2'h3);
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    AST_OFF_NO_DRIVE: assert property (offc_q == 2'h3 |-> &pad_oe_n)
        else $error("pin driven while crossbar off");
    AST_OFF_FN_IN: assert property (offc_q == 2'h3 |-> fn_in == '0)
        else $error("function input live while crossbar off");
    AST_PUD_ALL: assert property (pudc_q == 2'h3 |-> pad_weak_pu == '0)
        else $error("weak pull-up on while globally off");
    AST_DRIVE_NO_PU: assert property ((~pad_oe_n & pad_weak_pu) == '0)
        else $error("weak pull-up on a driving pin");
    AST_STRONG_PU: assert property (strong_pullup_on == lo_q[7])
        else $error("strong pull-up does not follow its bit");
    AST_RESET_OUT: assert property ($past(rst) |-> &pad_oe_n &&
        &pad_weak_pu && pad_out == '0 && fn_in == '0)
        else $error("outputs wrong after reset");
    AST_RDATA_HOLD: assert property (!$past(sfr_re) |-> $stable(sfr_rdata))
        else $error("read data changed without a read");
    AST_LO_READ: assert property ($past(sfr_re) &&
        $past(sfr_addr) == PCX_A_ROUTE_LO |-> sfr_rdata == $past(lo_q))
        else $error("low route register read wrong");
    AST_HI_READ: assert property ($past(sfr_re) &&
        $past(sfr_addr) == PCX_A_ROUTE_HI
        |-> sfr_rdata == ($past(hi_q) & PCX_ROUTE_HI_MASK))
        else $error("high route register read wrong");
    AST_UNMAPPED: assert property ($past(sfr_re) && !$past(mapped)
        |-> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // pcx_crossbar_props
bind pcx_crossbar pcx_crossbar_props u_props (.mclk, .rst, .sfr_addr,
    .sfr_wdata, .sfr_we, .sfr_re, .sfr_rdata, .fn_in, .pad_out, .pad_oe_n,
    .pad_weak_pu, .strong_pullup_on);
`default_nettype wire

// >>> sim/pcx_pin_world.sv
// Board-side model of the port pins, with pull-ups and external drivers.
`timescale 1ns/1ps
`default_nettype none
module pcx_pin_world (
    input wire logic mclk,
    input wire logic [19:0] pad_out,
    input wire logic [19:0] pad_oe_n,
    input wire logic [19:0] pad_weak_pu,
    input wire logic [19:0] ext_en,
    input wire logic [19:0] ext_val,
    output logic [19:0] pad_in
);
    import pcx_pkg::*;
    logic [19:0] float_q = 20'h5_5555;
    // An undriven, unpulled pad wanders so a stale level never passes.
    always @(posedge mclk) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < PCX_NPIN; i++) begin
            if (!pad_oe_n[i])
                pad_in[i] = (ext_en[i] && ext_val[i] != pad_out[i]) ?
                    1'bx : pad_out[i];
            else if (ext_en[i])
                pad_in[i] = ext_val[i];
            else if (pad_weak_pu[i])
                pad_in[i] = 1'b1;
            else
                pad_in[i] = float_q[i];
        end
    end
endmodule // pcx_pin_world
`default_nettype wire

// >>> sim/priority_pin_crossbar_test.sv
// Self-checking testbench of the priority pin crossbar.
`timescale 1ns/1ps
`default_nettype none
module priority_pin_crossbar_test;
    import pcx_pkg::*;
    logic mclk, rst, sfr_we, sfr_re, strong_pullup_on;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [1:0] spi_select_mode, smbus_pin_swap;
    logic [18:0] fn_out, fn_oe, fn_in;
    logic [19:0] pad_in, pad_out, pad_oe_n, pad_weak_pu, ext_en, ext_val;
    int num_errors = 0;
    int checks = 0;
    pcx_crossbar uut (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr),
        .sfr_wdata(sfr_wdata), .sfr_we(sfr_we), .sfr_re(sfr_re),
        .sfr_rdata(sfr_rdata), .spi_select_mode(spi_select_mode),
        .smbus_pin_swap(smbus_pin_swap), .fn_out(fn_out), .fn_oe(fn_oe),
        .fn_in(fn_in), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pad_weak_pu(pad_weak_pu),
        .strong_pullup_on(strong_pullup_on));
    pcx_pin_world world (.mclk(mclk), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pad_weak_pu(pad_weak_pu), .ext_en(ext_en),
        .ext_val(ext_val), .pad_in(pad_in));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic end_of_test();
        if (num_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [19:0] g, input logic [19:0] e);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_we = 1'b1;
        @(negedge mclk);
        sfr_we = 1'b0;
        @(negedge mclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        sfr_addr = a;
        sfr_re = 1'b1;
        @(negedge mclk);
        sfr_re = 1'b0;
        @(negedge mclk);
        chk(20'(sfr_rdata), 20'(e));
    endtask
    task automatic sett();
        repeat (4) @(negedge mclk);
    endtask
    task automatic do_reset();
        rst = 1'b1;
        repeat (16) @(negedge mclk);
        rst = 1'b0;
    endtask
    task automatic t_reset();
        chk(pad_oe_n, 20'hF_FFFF);
        chk(pad_weak_pu, 20'hF_FFFF);
        rd(PCX_A_MDIN0, 8'hFF);
        rd(PCX_A_MDIN2, 8'h0F);
        rd(PCX_A_ROUTE_LO, 8'h00);
        rd(8'h33, 8'h00);
    endtask
    task automatic t_route();
        fn_out = 19'h7_FEBF;
        fn_oe = 19'h7_FFFD;
        ext_en[5] = 1'b1;
        wr(PCX_A_MDOUT0, 8'hFF);
        wr(PCX_A_ROUTE_LO, 8'h47);
        sett();
        chk(pad_oe_n, 20'hF_FFFF);
        chk(20'(fn_in), 20'h0_0000);
        wr(PCX_A_ROUTE_HI, 8'h40);
        sett();
        chk(pad_oe_n, 20'h0_0160);
        chk(pad_out, 20'h0_0037);
        chk(pad_weak_pu, 20'h0_0160);
        chk(20'(fn_in[1]), 20'h0_0000);
        ext_val[5] = 1'b1;
        sett();
        chk(20'(fn_in[1]), 20'h0_0001);
    endtask
    task automatic t_swap();
        smbus_pin_swap = 2'h1;
        sett();
        chk(pad_oe_n, 20'h0_0128);
        smbus_pin_swap = 2'h3;
        sett();
        chk(pad_oe_n, 20'h0_00A8);
    endtask
    task automatic t_spi();
        smbus_pin_swap = 2'h0;
        spi_select_mode = 2'h1;
        sett();
        chk(pad_oe_n, 20'h0_02A0);
        spi_select_mode = 2'h0;
    endtask
    task automatic t_skip();
        wr(PCX_A_ROUTE_HI, 8'h00);
        wr(PCX_A_MDOUT0, 8'h00);
        wr(PCX_A_LATCH0, 8'hFF);
        wr(PCX_A_LATCH1, 8'hFF);
        wr(PCX_A_LATCH2, 8'h0F);
        wr(PCX_A_SKIP0, 8'h0C);
        wr(PCX_A_ROUTE_LO, 8'h05);
        wr(PCX_A_ROUTE_HI, 8'h41);
        fn_out = '0;
        fn_oe = 19'h0_2040;
        sett();
        chk(pad_oe_n, 20'hF_FFBE);
    endtask
    task automatic t_cex();
        wr(PCX_A_SKIP0, 8'h00);
        wr(PCX_A_ROUTE_LO, 8'h00);
        fn_oe = 19'h0_E000;
        for (int k = 0; k < 4; k++) begin
            wr(PCX_A_ROUTE_HI, 8'h40 | 8'(k));
            sett();
            chk(pad_oe_n, 20'hF_FFFF << k);
        end
    endtask
    task automatic t_analog();
        wr(PCX_A_MDIN0, 8'hFE);
        ext_en[0] = 1'b1;
        ext_val[0] = 1'b1;
        sett();
        chk(20'({pad_oe_n[0], pad_weak_pu[0]}), 20'h0_0002);
        rd(PCX_A_LATCH0, 8'hF8);
        ext_en[0] = 1'b0;
        wr(PCX_A_MDIN0, 8'hFF);
        sett();
        chk(20'(pad_oe_n[0]), 20'h0_0000);
    endtask
    task automatic t_regs();
        wr(PCX_A_ROUTE_HI, 8'hC0);
        sett();
        chk(pad_weak_pu, 20'h0_0000);
        wr(PCX_A_ROUTE_LO, 8'h80);
        chk(20'(strong_pullup_on), 20'h0_0001);
        rd(PCX_A_ROUTE_LO, 8'h80);
        wr(PCX_A_ROUTE_HI, 8'hFF);
        rd(PCX_A_ROUTE_HI, 8'hFB);
    endtask
    initial begin
        repeat (3000) @(posedge mclk);
        num_errors++;
        end_of_test();
    end
    initial begin
        {sfr_we, sfr_re, sfr_addr, sfr_wdata} = '0;
        {spi_select_mode, smbus_pin_swap, fn_out, fn_oe} = '0;
        {ext_en, ext_val} = '0;
        // Reset stands from time zero so no edge sees unreset state.
        do_reset();
        t_reset();
        t_route();
        t_swap();
        t_spi();
        t_skip();
        t_cex();
        t_analog();
        t_regs();
        do_reset();
        t_reset();
        end_of_test();
    end
endmodule // priority_pin_crossbar_test
`default_nettype wire
